/* File: hdl/gcf_pkg.sv */
package gcf_pkg;
    // Data path widths
    localparam int POS_W = 32;
    localparam int RAT_W = 16;
    localparam int PROD_W = 64;
    localparam int DIV_STEPS = PROD_W;
    localparam logic [6:0] DIV_CNT_INIT = 7'h40;

    // Register byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_RATIO = 8'h04;
    localparam logic [7:0] OFF_SEG_LEN = 8'h08;
    localparam logic [7:0] OFF_CYCLE = 8'h0c;
    localparam logic [7:0] OFF_MOFF = 8'h10;
    localparam logic [7:0] OFF_SOFF = 8'h14;
    localparam logic [7:0] OFF_ROWS = 8'h18;
    localparam logic [7:0] OFF_TBL_IDX = 8'h1c;
    localparam logic [7:0] OFF_TBL_DATA = 8'h20;
    localparam logic [7:0] OFF_STATUS = 8'h24;
    localparam logic [7:0] OFF_CMD = 8'h28;

    // Register field positions
    localparam int CTRL_GEAR_EN = 0;
    localparam int CTRL_CAM_EN = 1;
    localparam int CTRL_ABS = 2;
    localparam int CTRL_SOFF_EN = 3;
    localparam int CTRL_SRC_LSB = 4;
    localparam int RATIO_DEN_LSB = 16;
    localparam int STAT_BUSY = 8;

    // Master source selections
    localparam logic [1:0] SRC_ENC = 2'h0;
    localparam logic [1:0] SRC_ADC = 2'h1;
    localparam logic [1:0] SRC_AXIS = 2'h2;

    // Reset values
    localparam logic [5:0] CTRL_RST = 6'h00;
    localparam logic [15:0] NUM_RST = 16'h0001;
    localparam logic [15:0] DEN_RST = 16'h0001;
    localparam logic [31:0] SEG_LEN_RST = 32'h0000_07d0;
    localparam logic [31:0] CYCLE_RST = 32'h0000_1770;

    typedef enum {ST_IDLE, ST_DIV, ST_DONE} gcf_state_e;
endpackage

/* File: hdl/gcf_follower.sv */
`timescale 1ns/1ps
// How it works
// - Gear output is master travel times ratio
// - Relative mode recaptures reference on enable, ratio
// - Absolute mode captures reference only at enable
// - Absolute ratio change recomputes immediately, steps slave
// - Ratio step applied without acceleration limiting
// - Superimposed move is added to following profile
// - Cam profile comes from loaded table buffer
// - Segment ratio is slave delta over master delta
// - Master wraps modulo cycle, profile restarts
// - Segment holds through its upper boundary inclusive
// - Table breakpoints equally spaced over cycle
// - Slave offset keeps tabulated positions each cycle
// - Master offset shifts all segment boundaries
// - Master is encoder, ADC or axis trajectory
module gcf_follower
    import gcf_pkg::*;
#(
    parameter int TBL_AW = 4,
    parameter int ADC_W = 16
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Master sources
    input wire logic sample_valid,
    input wire logic signed [POS_W-1:0] enc_pos,
    input wire logic [ADC_W-1:0] adc_val,
    input wire logic signed [POS_W-1:0] axis_traj_pos,
    // Superimposed move from the slave trajectory generator
    input wire logic signed [POS_W-1:0] sup_pos,
    // Slave command
    output logic signed [POS_W-1:0] cmd_pos,
    output logic cmd_valid,
    output logic busy
);
    localparam int DEPTH = 1 << TBL_AW;

    // Sign-magnitude helper for the divider dividend
    function automatic logic [PROD_W-1:0] mag(input logic signed [PROD_W-1:0] v);
        mag = v[PROD_W-1] ? (~v + 64'h1) : v;
    endfunction

    // Registers and next values
    gcf_state_e state_r, state_nxt;
    logic [5:0] ctrl_r, ctrl_nxt; // Mode bits and source select
    logic [RAT_W-1:0] num_r, num_nxt, den_r, den_nxt;
    logic [31:0] seg_len_r, seg_len_nxt, cycle_r, cycle_nxt;
    logic [31:0] moff_r, moff_nxt;
    logic signed [POS_W-1:0] soff_r, soff_nxt;
    logic [TBL_AW:0] rows_r, rows_nxt; // Table rows, segments are rows minus one
    logic [TBL_AW-1:0] tidx_r, tidx_nxt;
    logic signed [POS_W-1:0] tbl_r [DEPTH]; // Cam table slave positions
    logic signed [POS_W-1:0] master_r, master_nxt; // Last master sample
    logic signed [POS_W-1:0] ref_r, ref_nxt; // Gear reference
    logic signed [POS_W-1:0] gbase_r, gbase_nxt; // Gear carry-over
    logic signed [POS_W-1:0] gq_r, gq_nxt; // Last gear quotient
    logic signed [POS_W-1:0] cbase_r, cbase_nxt; // Cam cycle carry
    logic signed [POS_W-1:0] phase_r, phase_nxt; // Wrapped master
    logic signed [POS_W-1:0] sstart_r, sstart_nxt; // Segment start
    logic [TBL_AW-1:0] seg_r, seg_nxt;
    logic pend_r, pend_nxt; // Recompute without new sample
    logic [PROD_W-1:0] dvd_r, dvd_nxt, quo_r, quo_nxt;
    logic [32:0] rem_r, rem_nxt;
    logic [31:0] dvs_r, dvs_nxt;
    logic neg_r, neg_nxt;
    logic [6:0] cnt_r, cnt_nxt;
    logic signed [POS_W-1:0] follow_r, follow_nxt; // Following profile
    logic signed [POS_W-1:0] cmd_nxt;
    logic cmd_valid_nxt;

    // Combinational helpers
    logic wr, rd, tbl_we;
    logic [TBL_AW-1:0] last_seg;
    logic signed [POS_W-1:0] msel, ph, st;
    logic [TBL_AW-1:0] sg;
    logic signed [PROD_W-1:0] prod;
    logic [32:0] rem_sh;

    assign wr = psel && penable && pwrite;
    assign rd = psel && !pwrite;
    assign pready = 1'b1; // Zero wait state
    assign busy = (state_r != ST_IDLE);
    assign last_seg = TBL_AW'(rows_r - 1'b1) - 1'b1;
    assign tbl_we = wr && (paddr == OFF_TBL_DATA);

    // Read mux and error flag
    always_comb begin
        prdata = 32'h0;
        pslverr = 1'b0;
        if (paddr == OFF_CTRL) begin
            prdata = 32'(ctrl_r);
        end else if (paddr == OFF_RATIO) begin
            prdata = {den_r, num_r};
        end else if (paddr == OFF_SEG_LEN) begin
            prdata = seg_len_r;
        end else if (paddr == OFF_CYCLE) begin
            prdata = cycle_r;
        end else if (paddr == OFF_MOFF) begin
            prdata = moff_r;
        end else if (paddr == OFF_SOFF) begin
            prdata = soff_r;
        end else if (paddr == OFF_ROWS) begin
            prdata = 32'(rows_r);
        end else if (paddr == OFF_TBL_IDX) begin
            prdata = 32'(tidx_r);
        end else if (paddr == OFF_TBL_DATA) begin
            prdata = tbl_r[tidx_r];
        end else if (paddr == OFF_STATUS) begin
            prdata = 32'(seg_r) | (32'(busy) << STAT_BUSY);
        end else if (paddr == OFF_CMD) begin
            prdata = cmd_pos;
        end else begin
            pslverr = psel && penable; // Unmapped address
        end
        if (!rd) begin
            prdata = 32'h0;
        end
    end

    // Master source selection
    always_comb begin
        if (ctrl_r[CTRL_SRC_LSB +: 2] == SRC_ADC) begin
            msel = POS_W'(adc_val); // Binary code used as a position
        end else if (ctrl_r[CTRL_SRC_LSB +: 2] == SRC_AXIS) begin
            msel = axis_traj_pos;
        end else begin
            msel = enc_pos;
        end
    end

    // Next-state logic for configuration, tracking and divider
    always_comb begin
        state_nxt = state_r;
        ctrl_nxt = ctrl_r;
        num_nxt = num_r;
        den_nxt = den_r;
        seg_len_nxt = seg_len_r;
        cycle_nxt = cycle_r;
        moff_nxt = moff_r;
        soff_nxt = soff_r;
        rows_nxt = rows_r;
        tidx_nxt = tidx_r;
        master_nxt = master_r;
        ref_nxt = ref_r;
        gbase_nxt = gbase_r;
        gq_nxt = gq_r;
        cbase_nxt = cbase_r;
        phase_nxt = phase_r;
        sstart_nxt = sstart_r;
        seg_nxt = seg_r;
        pend_nxt = pend_r;
        dvd_nxt = dvd_r;
        quo_nxt = quo_r;
        rem_nxt = rem_r;
        dvs_nxt = dvs_r;
        neg_nxt = neg_r;
        cnt_nxt = cnt_r;
        follow_nxt = follow_r;
        cmd_nxt = cmd_pos;
        cmd_valid_nxt = 1'b0;
        ph = phase_r;
        st = sstart_r;
        sg = seg_r;
        prod = '0;
        rem_sh = '0;
        // Register writes
        if (wr) begin
            if (paddr == OFF_CTRL) begin
                ctrl_nxt = pwdata[5:0];
                if (pwdata[CTRL_GEAR_EN] && !ctrl_r[CTRL_GEAR_EN]) begin
                    ref_nxt = master_r; // Capture on enable
                    gbase_nxt = follow_r;
                    gq_nxt = '0;
                end
                if (pwdata[CTRL_CAM_EN] && !ctrl_r[CTRL_CAM_EN]) begin
                    // Start cycle shifted by the master offset
                    phase_nxt = (moff_r == 32'h0) ? '0 : cycle_r - moff_r;
                    seg_nxt = (moff_r == 32'h0) ? '0 : last_seg;
                    sstart_nxt = (moff_r == 32'h0) ? '0 : cycle_r - seg_len_r;
                    cbase_nxt = '0;
                end
            end else if (paddr == OFF_RATIO) begin
                num_nxt = pwdata[RAT_W-1:0];
                den_nxt = pwdata[RATIO_DEN_LSB +: RAT_W];
                if (!ctrl_r[CTRL_ABS]) begin
                    ref_nxt = master_r; // Relative: no jump
                    gbase_nxt = gbase_r + gq_r;
                    gq_nxt = '0;
                end
                // Recompute at once, step is unlimited
                pend_nxt = ctrl_r[CTRL_GEAR_EN];
            end else if (paddr == OFF_SEG_LEN) begin
                seg_len_nxt = pwdata;
            end else if (paddr == OFF_CYCLE) begin
                cycle_nxt = pwdata;
            end else if (paddr == OFF_MOFF) begin
                moff_nxt = pwdata;
            end else if (paddr == OFF_SOFF) begin
                soff_nxt = pwdata;
            end else if (paddr == OFF_ROWS) begin
                rows_nxt = pwdata[TBL_AW:0];
            end else if (paddr == OFF_TBL_IDX) begin
                tidx_nxt = pwdata[TBL_AW-1:0];
            end else if (paddr == OFF_TBL_DATA) begin
                tidx_nxt = tidx_r + 1'b1; // Stream the table
            end
        end
        case (state_r)
            ST_IDLE: begin
                if (sample_valid || pend_r) begin
                    // A ratio load in this same cycle keeps its recompute pending
                    pend_nxt = wr && (paddr == OFF_RATIO) && ctrl_r[CTRL_GEAR_EN];
                    if (sample_valid) begin
                        master_nxt = msel;
                    end
                    if (ctrl_r[CTRL_CAM_EN]) begin
                        // Wrap master travel into the cycle
                        ph = phase_r + (master_nxt - master_r);
                        if (ph >= $signed(cycle_r)) begin
                            ph = ph - $signed(cycle_r);
                            st = '0;
                            sg = '0;
                            if (!ctrl_r[CTRL_SOFF_EN]) begin
                                cbase_nxt = cbase_r + tbl_r[last_seg + 1'b1] - tbl_r[0];
                            end
                        end else if (ph < 0) begin
                            ph = ph + $signed(cycle_r);
                            st = $signed(cycle_r - seg_len_r);
                            sg = last_seg;
                            if (!ctrl_r[CTRL_SOFF_EN]) begin
                                cbase_nxt = cbase_r - tbl_r[last_seg + 1'b1] + tbl_r[0];
                            end
                        end
                        // Interval is (start, start+len], upper bound kept
                        if (ph > st + $signed(seg_len_r) && sg != last_seg) begin
                            st = st + $signed(seg_len_r);
                            sg = sg + 1'b1;
                        end else if (ph <= st && sg != '0) begin
                            st = st - $signed(seg_len_r);
                            sg = sg - 1'b1;
                        end
                        phase_nxt = ph;
                        sstart_nxt = st;
                        seg_nxt = sg;
                        // Slave delta times master travel
                        prod = PROD_W'(tbl_r[sg + 1'b1] - tbl_r[sg]) * PROD_W'(ph - st);
                        dvs_nxt = seg_len_r;
                    end else begin
                        // Master travel from reference times numerator
                        prod = PROD_W'(master_nxt - ref_r) * PROD_W'($signed(num_r));
                        dvs_nxt = 32'(den_r);
                    end
                    neg_nxt = prod[PROD_W-1];
                    dvd_nxt = mag(prod);
                    rem_nxt = '0;
                    quo_nxt = '0;
                    cnt_nxt = DIV_CNT_INIT;
                    state_nxt = ST_DIV;
                end
            end
            ST_DIV: begin
                // Restoring divide, one quotient bit per cycle
                rem_sh = {rem_r[31:0], dvd_r[PROD_W-1]};
                dvd_nxt = {dvd_r[PROD_W-2:0], 1'b0};
                if (rem_sh >= {1'b0, dvs_r} && dvs_r != 32'h0) begin
                    rem_nxt = rem_sh - {1'b0, dvs_r};
                    quo_nxt = {quo_r[PROD_W-2:0], 1'b1};
                end else begin
                    rem_nxt = rem_sh;
                    quo_nxt = {quo_r[PROD_W-2:0], 1'b0};
                end
                cnt_nxt = cnt_r - 1'b1;
                if (cnt_r == 7'h01) begin
                    state_nxt = ST_DONE;
                end
            end
            ST_DONE: begin
                if (ctrl_r[CTRL_CAM_EN]) begin
                    // Segment start plus ratio share
                    follow_nxt = tbl_r[seg_r] + cbase_r
                        + (neg_r ? -$signed(quo_r[POS_W-1:0]) : $signed(quo_r[POS_W-1:0]));
                end else if (ctrl_r[CTRL_GEAR_EN]) begin
                    gq_nxt = neg_r ? -$signed(quo_r[POS_W-1:0]) : $signed(quo_r[POS_W-1:0]);
                    follow_nxt = gbase_r + gq_nxt;
                end
                cmd_nxt = follow_nxt + sup_pos; // Superimposed move added
                cmd_valid_nxt = 1'b1;
                state_nxt = ST_IDLE;
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    // State registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= ST_IDLE;
            ctrl_r <= CTRL_RST;
            num_r <= NUM_RST;
            den_r <= DEN_RST;
            seg_len_r <= SEG_LEN_RST;
            cycle_r <= CYCLE_RST;
            moff_r <= '0;
            soff_r <= '0;
            rows_r <= '0;
            tidx_r <= '0;
            master_r <= '0;
            ref_r <= '0;
            gbase_r <= '0;
            gq_r <= '0;
            cbase_r <= '0;
            phase_r <= '0;
            sstart_r <= '0;
            seg_r <= '0;
            pend_r <= 1'b0;
            dvd_r <= '0;
            quo_r <= '0;
            rem_r <= '0;
            dvs_r <= '0;
            neg_r <= 1'b0;
            cnt_r <= '0;
            follow_r <= '0;
            cmd_pos <= '0;
            cmd_valid <= 1'b0;
        end else begin
            state_r <= state_nxt;
            ctrl_r <= ctrl_nxt;
            num_r <= num_nxt;
            den_r <= den_nxt;
            seg_len_r <= seg_len_nxt;
            cycle_r <= cycle_nxt;
            moff_r <= moff_nxt;
            soff_r <= soff_nxt;
            rows_r <= rows_nxt;
            tidx_r <= tidx_nxt;
            master_r <= master_nxt;
            ref_r <= ref_nxt;
            gbase_r <= gbase_nxt;
            gq_r <= gq_nxt;
            cbase_r <= cbase_nxt;
            phase_r <= phase_nxt;
            sstart_r <= sstart_nxt;
            seg_r <= seg_nxt;
            pend_r <= pend_nxt;
            dvd_r <= dvd_nxt;
            quo_r <= quo_nxt;
            rem_r <= rem_nxt;
            dvs_r <= dvs_nxt;
            neg_r <= neg_nxt;
            cnt_r <= cnt_nxt;
            follow_r <= follow_nxt;
            cmd_pos <= cmd_nxt;
            cmd_valid <= cmd_valid_nxt;
        end
    end

    // Table memory has no reset, software loads it before use
    always_ff @(posedge pclk) begin
        if (tbl_we) begin
            tbl_r[tidx_r] <= pwdata;
        end
    end

    // Checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_start;
        state_r == ST_IDLE && (sample_valid || pend_r);
    endsequence
    sequence s_result;
        ##66 cmd_valid;
    endsequence

    a_calc_latency: assert property (s_start |-> s_result)
        else $error("command not issued 66 cycles after start");
    a_rel_recapture: assert property (wr && paddr == OFF_RATIO && !ctrl_r[CTRL_ABS]
        |=> ref_r == $past(master_r))
        else $error("relative ratio load did not recapture reference");
    a_abs_ref_kept: assert property (wr && paddr == OFF_RATIO && ctrl_r[CTRL_ABS]
        && ctrl_r[CTRL_GEAR_EN] |=> $stable(ref_r))
        else $error("absolute ratio load moved reference");
    a_abs_step: assert property (wr && paddr == OFF_RATIO && ctrl_r[CTRL_GEAR_EN]
        |-> ##[1:140] cmd_valid)
        else $error("ratio change not followed by new command");
    a_sup_added: assert property (state_r == ST_DONE
        |=> cmd_pos == follow_r + $past(sup_pos))
        else $error("superimposed move not added");
    a_tbl_store: assert property (tbl_we
        |=> tbl_r[$past(tidx_r)] == $past(pwdata) && tidx_r == $past(tidx_r) + 1'b1)
        else $error("table word not stored");
    a_phase_wrap: assert property (ctrl_r[CTRL_CAM_EN] && state_r == ST_DIV && cycle_r != 0
        |-> phase_r >= 0 && phase_r < $signed(cycle_r))
        else $error("master phase outside cycle");
    a_seg_bound: assert property (ctrl_r[CTRL_CAM_EN] && state_r == ST_DIV && seg_r != last_seg
        |-> phase_r <= sstart_r + $signed(seg_len_r))
        else $error("segment not advanced past upper bound");
endmodule

/* File: tb/gcf_axis_partner.sv */
`timescale 1ns/1ps
module gcf_axis_partner
    import gcf_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Slave command
    input wire logic signed [POS_W-1:0] cmd_pos,
    input wire logic cmd_valid,
    // Master samples
    output logic sample_valid,
    output logic signed [POS_W-1:0] enc_pos,
    output logic [15:0] adc_val,
    output logic signed [POS_W-1:0] axis_traj_pos,
    output logic signed [POS_W-1:0] sup_pos
);
    int seed = 52337; // Noise for the sources not selected
    logic signed [POS_W-1:0] slave_pos; // Last command the loop follows

    // Quiet sources at time zero
    initial begin
        sample_valid = 1'b0;
        enc_pos = '0;
        adc_val = '0;
        axis_traj_pos = '0;
        sup_pos = '0;
    end

    // Slave loop jumps to each command, no ramp
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            slave_pos <= '0;
        end else if (cmd_valid) begin
            slave_pos <= cmd_pos;
        end
    end

    // One sample pulse; idle sources get noise so a wrong pick shows
    task automatic send(input logic [1:0] src, input logic signed [31:0] pos,
                        input logic signed [31:0] sup);
        logic signed [31:0] e;
        logic signed [31:0] x;
        logic [15:0] a;
        e = $random(seed);
        x = $random(seed);
        a = 16'($random(seed));
        if (src == SRC_ENC) e = pos;
        else if (src == SRC_ADC) a = pos[15:0];
        else x = pos;
        @(posedge pclk);
        enc_pos <= e;
        adc_val <= a;
        axis_traj_pos <= x;
        sup_pos <= sup;
        sample_valid <= 1'b1;
        @(posedge pclk);
        sample_valid <= 1'b0;
    endtask
endmodule

/* File: tb/gcf_follower_bench.sv */
`timescale 1ns/1ps
module gcf_follower_bench
    import gcf_pkg::*;
;
    // Clock, reset and bus
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    // Sample stream and command
    logic sample_valid;
    logic signed [POS_W-1:0] enc_pos;
    logic [15:0] adc_val;
    logic signed [POS_W-1:0] axis_traj_pos;
    logic signed [POS_W-1:0] sup_pos;
    logic signed [POS_W-1:0] cmd_pos;
    logic cmd_valid;
    logic busy;
    // Scoreboard; bit 32 of a note set means compare
    int fail_count = 0;
    int samples_checked = 0;
    logic [32:0] notes[$];
    logic [32:0] cur;
    int tbl[4];
    int mpts[4] = '{7050, 8050, 8060, 9050};
    int m;

    always #5 pclk = ~pclk;

    gcf_follower #(.TBL_AW(4), .ADC_W(16)) uut (.pclk(pclk), .presetn(presetn),
        .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .sample_valid(sample_valid),
        .enc_pos(enc_pos), .adc_val(adc_val), .axis_traj_pos(axis_traj_pos),
        .sup_pos(sup_pos), .cmd_pos(cmd_pos), .cmd_valid(cmd_valid), .busy(busy));

    gcf_axis_partner partner (.pclk(pclk), .presetn(presetn), .cmd_pos(cmd_pos),
        .cmd_valid(cmd_valid), .sample_valid(sample_valid), .enc_pos(enc_pos),
        .adc_val(adc_val), .axis_traj_pos(axis_traj_pos), .sup_pos(sup_pos));

    // Verdict and end of run
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // One compare for every value kind
    task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // APB transfer; read data and error taken at the pready edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       input logic [31:0] exp, input logic err);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 50) begin
            n++;
            @(posedge pclk);
        end
        if (!wr) check_val(prdata, exp);
        check_val({31'h0, pslverr}, {31'h0, err});
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 32'h0, 1'b0);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0, exp, 1'b0);
    endtask

    // Bounded wait for the next command pulse
    task automatic wait_cmd();
        int n;
        n = 0;
        @(posedge pclk);
        while (cmd_valid !== 1'b1 && n < 200) begin
            n++;
            @(posedge pclk);
        end
        if (n >= 200) begin
            fail_count++;
            $display("unexpected hang at %0t: got %h expected %h", $time, 1'b0, 1'b1);
        end
    endtask

    // Note the outcome, send the sample, wait for its command
    task automatic smp(input logic [1:0] src, input logic signed [31:0] pos,
                       input logic signed [31:0] sup, input logic chk,
                       input logic signed [31:0] exp);
        notes.push_back({chk, exp});
        partner.send(src, pos, sup);
        @(posedge pclk);
        check_val({31'h0, busy}, 32'h1);
        wait_cmd();
    endtask

    // Tabulated slave position of a master position, 2000-count segments
    function automatic int cam_at(input int mst, input int moff);
        int p;
        int s;
        p = (mst - moff) % 6000;
        if (p < 0) p += 6000;
        s = (p == 0) ? 0 : (p - 1) / 2000;
        return tbl[s] + (tbl[s + 1] - tbl[s]) * (p - s * 2000) / 2000;
    endfunction

    // Load four rows, slave ends at last
    task automatic load_tbl(input int last);
        tbl = '{0, 2000, 1000, last};
        wr(OFF_ROWS, 32'd4);
        wr(OFF_TBL_IDX, 32'd0);
        foreach (tbl[i]) wr(OFF_TBL_DATA, 32'(tbl[i]));
    endtask

    // Oldest note against each command that appears
    always @(posedge pclk) begin
        if (cmd_valid === 1'b1) begin
            if (notes.size() == 0) begin
                fail_count++;
                $display("unexpected command at %0t: got %h expected %h", $time, cmd_pos, 0);
            end else begin
                cur = notes.pop_front();
                if (cur[32]) check_val(cmd_pos, cur[31:0]);
            end
        end
    end

    // Hang guard, several times the expected run
    initial begin
        #(30000 * 10);
        fail_count++;
        $display("unexpected timeout at %0t: got %h expected %h", $time, 1'b0, 1'b1);
        print_verdict();
    end

    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        rd(OFF_CTRL, {26'h0, CTRL_RST});
        rd(OFF_RATIO, {DEN_RST, NUM_RST});
        rd(OFF_SEG_LEN, SEG_LEN_RST);
        rd(OFF_CYCLE, CYCLE_RST);
        apb(1'b1, 8'h3c, 32'h1, 32'h0, 1'b1);
        apb(1'b0, 8'h3c, 32'h0, 32'h0, 1'b1);
        rd(OFF_CTRL, 32'h0);
        $display("test reset_regs done");
        wr(OFF_RATIO, {16'h1, 16'h2});
        smp(SRC_ENC, 1000, 0, 1'b0, 0);
        wr(OFF_CTRL, 32'h1);
        smp(SRC_ENC, 1010, 0, 1'b1, 10 * 2);
        notes.push_back({1'b1, 32'd20});
        wr(OFF_RATIO, {16'h1, 16'h3});
        wait_cmd();
        smp(SRC_ENC, 1020, 0, 1'b1, 20 + 10 * 3);
        smp(SRC_ENC, 1040, 7, 1'b1, 50 + 20 * 3 + 7);
        $display("test relative_gear done");
        wr(OFF_CTRL, 32'h0);
        wr(OFF_RATIO, {16'h1, 16'h2});
        wr(OFF_CTRL, 32'h5);
        // Gearing resumes from the 110 the following profile held at enable
        smp(SRC_ENC, 1050, 0, 1'b1, 110 + 10 * 2);
        notes.push_back({1'b1, 32'd140});
        wr(OFF_RATIO, {16'h1, 16'h3});
        wait_cmd();
        notes.push_back({1'b1, 32'd130});
        wr(OFF_RATIO, {16'h2, 16'h4});
        wait_cmd();
        smp(SRC_ENC, 1070, 0, 1'b1, 110 + 30 * 4 / 2);
        $display("test absolute_gear done");
        wr(OFF_CTRL, 32'h10);
        smp(SRC_ADC, 5000, 0, 1'b0, 0);
        wr(OFF_CTRL, 32'h11);
        smp(SRC_ADC, 5040, 0, 1'b1, 170 + 40 * 2);
        wr(OFF_CTRL, 32'h20);
        smp(SRC_AXIS, -3000, 0, 1'b0, 0);
        wr(OFF_CTRL, 32'h21);
        smp(SRC_AXIS, -3100, 0, 1'b1, 250 - 100 * 2);
        $display("test sources done");
        wr(OFF_CTRL, 32'h0);
        smp(SRC_ENC, 0, 0, 1'b0, 0);
        load_tbl(0);
        wr(OFF_CYCLE, 32'd6000);
        wr(OFF_SEG_LEN, 32'd2000);
        wr(OFF_MOFF, 32'd0);
        wr(OFF_CTRL, 32'h2);
        for (m = 1000; m <= 7000; m += 1000) begin
            smp(SRC_ENC, m, 0, 1'b1, cam_at(m, 0));
        end
        wr(OFF_CTRL, 32'h0);
        wr(OFF_MOFF, 32'd50);
        wr(OFF_CTRL, 32'h2);
        // Cam phase counts from the master position at enable, here 7000
        foreach (mpts[i]) smp(SRC_ENC, mpts[i], 0, 1'b1, cam_at(mpts[i] - 7000, 50));
        $display("test cam_table done");
        wr(OFF_CTRL, 32'h0);
        wr(OFF_MOFF, 32'd0);
        load_tbl(500);
        wr(OFF_SOFF, 32'd500);
        rd(OFF_SOFF, 32'd500);
        wr(OFF_CTRL, 32'ha);
        // Enabled at master 9050; the last sample wraps into a new cycle
        for (m = 10000; m <= 16000; m += 1000) begin
            smp(SRC_ENC, m, 0, 1'b1, cam_at(m - 9050, 0));
        end
        rd(OFF_CMD, 32'(cam_at(16000 - 9050, 0)));
        check_val(partner.slave_pos, 32'(cam_at(16000 - 9050, 0)));
        $display("test slave_offset done");
        print_verdict();
    end
endmodule
